// File: variable_length_symbol_decoder_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "vsd_map.svh"
module variable_length_symbol_decoder_test import vsd_pkg::*;;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic slow = 1'b0;
  logic [15:0] rdata;
  logic rvalid;
  logic stall;
  logic ack;
  logic [31:0] mdata;
  vsd_mem_req_t mem;
  int num_errors = 0;
  int checked = 0;
  int lat = 0;
  logic [15:0] d;
  // Table load; the ninth write wraps onto entry zero
  logic [15:0] tbl_w [9] = '{16'h007F, 16'h0002, 16'h0004, 16'h0008,
    16'h0010, 16'h0020, 16'h0040, 16'h0003, 16'h0001};
  // Decoded values of the two sample words, in stream order
  logic [15:0] exp_vals [19] = '{16'h0002, 16'h0001, 16'h0002, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0008, 16'h0001, 16'h0001, 16'h0005,
    16'h000B, 16'h0004, 16'h0000, 16'h000A, 16'h0002, 16'h0000, 16'h0000,
    16'h000D};
  // Clock
  always #4 clk = ~clk;
  vsd_top dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_rvalid(rvalid), .o_stall(stall), .o_mem(mem), .i_mem_ack(ack),
    .i_mem_data(mdata));
  vsd_mem_model mem_i (.i_clk(clk), .i_sys_rst(sys_rst), .i_mem(mem),
    .i_slow(slow), .o_ack(ack), .o_data(mdata));
  // Verdict and end of run
  task automatic end_sim();
    $display("checked %0d num_errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // Waits out a stall; no strobe is issued until the answer is seen
  task automatic rd_reg(input logic [2:0] a, output logic [15:0] v);
    int n;
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    n = 0;
    #1;
    while (rvalid !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    // Cycles spent waiting after the strobe, kept for timing checks
    lat = n;
    if (rvalid !== 1'b1) begin
      chk({15'h0000, rvalid}, 16'h0001);
    end
    v = rdata;
  endtask : rd_reg
  // Restart at a pointer with new modes, read three, then hold
  task automatic seq(input logic [15:0] plo, input logic [15:0] ctl,
      input logic [63:0] e);
    wr_reg(`VSD_A_PLO, plo);
    wr_reg(`VSD_A_CTRL, ctl);
    for (int k = 0; k < 4; k++) begin
      rd_reg(k == 3 ? `VSD_A_HOLD : `VSD_A_DATA, d);
      chk(d, e[63 - 16 * k -: 16]);
      // Second symbol has three bits, so it is ready four cycles after
      // the first delivery; the next strobe lands two cycles into that
      if (k == 1) begin
        chk(16'(lat), 16'h0002);
      end
    end
  endtask : seq
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    rd_reg(`VSD_A_CTRL, d);
    chk(d, `VSD_CTRL_RST);
    rd_reg(`VSD_A_RING, d);
    chk(d, {13'h0000, `VSD_RING_RST});
    wr_reg(`VSD_A_CTRL, 16'h0010);
    foreach (tbl_w[i]) wr_reg(`VSD_A_TABLE, tbl_w[i]);
    wr_reg(`VSD_A_CTRL, 16'h0020);
    @(posedge clk);
    for (int i = 0; i < 8; i++) begin
      rd_reg(`VSD_A_DATA, d);
      chk(d, i == 0 ? 16'h0001 : tbl_w[i]);
      @(posedge clk);
    end
    @(posedge clk);
    slow <= 1'b1;
    wr_reg(`VSD_A_PHI, 16'h0000);
    wr_reg(`VSD_A_PLO, 16'h0000);
    wr_reg(`VSD_A_CTRL, 16'h0000);
    foreach (exp_vals[i]) begin
      rd_reg(i == 18 ? `VSD_A_HOLD : `VSD_A_DATA, d);
      chk(d, exp_vals[i]);
    end
    repeat (20) @(posedge clk);
    rd_reg(`VSD_A_STAT, d);
    chk(d, 16'h0018);
    @(posedge clk);
    slow <= 1'b0;
    wr_reg(`VSD_A_RING, {13'h0000, `VSD_RING_64K});
    seq(16'h0004, 16'h8000, 64'h0001_0002_0001_0000);
    seq(16'h0003, 16'h0000, 64'h0002_0001_0002_0000);
    seq(16'h0000, 16'h2280, 64'h0003_0002_0003_0000);
    seq(16'h8000, 16'h2000, 64'h0002_0001_0002_0000);
    rd_reg(`VSD_A_PLO, d);
    chk({8'h00, d[15:8]}, 16'h0080);
    // Larger ring: a pointer above 64K words only decodes if bit 16 drops
    wr_reg(`VSD_A_RING, {13'h0000, `VSD_RING_128K});
    wr_reg(`VSD_A_PHI, 16'h0001);
    seq(16'h0000, 16'h2000, 64'h0002_0001_0002_0000);
    rd_reg(`VSD_A_PHI, d);
    chk(d, 16'h0001);
    wr_reg(`VSD_A_PHI, 16'h0000);
    wr_reg(`VSD_A_CTRL, 16'h0010);
    wr_reg(`VSD_A_TABLE, 16'h0084);
    seq(16'h0000, 16'h0040, 64'h0005_0004_0005_0000);
    end_sim();
  end
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    num_errors++;
    end_sim();
  end
endmodule : variable_length_symbol_decoder_test
bind vsd_top vsd_checker u_chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rvalid(o_rvalid), .o_stall(o_stall), .o_mem(o_mem),
  .i_mem_ack(i_mem_ack));
`default_nettype wire

// File: vsd_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "vsd_map.svh"
module vsd_checker import vsd_pkg::*; (
  input wire logic i_clk, // Clock
  input wire logic i_sys_rst, // Sync reset
  input wire logic [2:0] i_addr, // Register address
  input wire logic [15:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  input wire logic o_rvalid, // Read data valid
  input wire logic o_stall, // Data read waiting
  input wire vsd_mem_req_t o_mem, // Fetch request
  input wire logic i_mem_ack // Fetch done
);
  logic plo_wr;
  logic flushed;
  logic req_q;
  logic ring_on;
  logic [2:0] ring_sel;
  logic [31:0] last_addr;
  assign plo_wr = i_wr && i_addr == `VSD_A_PLO;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // Ring setup as the bus last wrote it
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ring_on <= 1'b0;
      ring_sel <= `VSD_RING_RST;
    end else if (i_wr && i_addr == `VSD_A_CTRL) begin
      ring_on <= i_wdata[13];
    end else if (i_wr && i_addr == `VSD_A_RING) begin
      ring_sel <= i_wdata[2:0];
    end
  end
  // Fetch history; a flush frees the next start address from the step
  always_ff @(posedge i_clk) begin
    req_q <= o_mem.req;
    if (o_mem.req && i_mem_ack) begin
      last_addr <= o_mem.addr;
    end
    if (i_sys_rst || plo_wr) begin
      flushed <= 1'b1;
    end else if (o_mem.req && !req_q) begin
      flushed <= 1'b0;
    end
  end
  a_read_answer: assert property (i_rd |=> o_rvalid || o_stall)
    else $error("read got no answer");
  a_stall_release: assert property ($fell(o_stall) |-> o_rvalid)
    else $error("stall ended without data");
  a_stall_quiet: assert property (o_stall |-> !o_rvalid)
    else $error("data valid during stall");
  a_req_holds: assert property (
    o_mem.req && !i_mem_ack && !plo_wr |=> o_mem.req && $stable(o_mem.addr))
    else $error("fetch request moved before ack");
  a_req_drops: assert property (o_mem.req && i_mem_ack |=> !o_mem.req)
    else $error("fetch request held after ack");
  a_ptr_step: assert property (
    $rose(o_mem.req) && !flushed |-> o_mem.addr == last_addr + `VSD_QW_STEP)
    else $error("fetch address did not step by two");
  a_addr_even: assert property (o_mem.req |-> !o_mem.addr[0])
    else $error("fetch address not double word aligned");
  a_ring_force: assert property (
    $rose(o_mem.req) && ring_on && ring_sel == `VSD_RING_64K
      |-> !o_mem.addr[`VSD_RBIT_64K])
    else $error("ring address bit not forced low");
endmodule : vsd_checker
`default_nettype wire

// File: vsd_fetch.sv
`timescale 1ns/10ps
`default_nettype none
`include "vsd_map.svh"
module vsd_fetch import vsd_pkg::*; (
  input wire logic i_clk, // System clock
  input wire logic i_sys_rst, // Sync reset, high
  input wire logic i_plo_we, // Pointer low write
  input wire logic i_phi_we, // Pointer high write
  input wire logic [15:0] i_wdata, // Pointer data
  input wire logic i_ring_en, // Ring buffer on
  input wire logic [2:0] i_ring_sel, // Ring size code
  input wire logic i_take, // Consume one bit
  output logic o_bit, // Current bit
  output logic o_bit_valid, // Current bit present
  output logic [31:0] o_ptr, // Pointer, word units
  output vsd_mem_req_t o_mem, // Fetch request
  input wire logic i_mem_ack, // Fetch done
  input wire logic [31:0] i_mem_data // Fetched word
);
  logic [31:0] cur_word;
  logic [5:0] cur_cnt;
  logic [31:0] pre_word;
  logic pre_valid;
  logic drop;
  logic load;

  // External address with the ring bit forced low
  function automatic logic [31:0] ring_map(input logic [31:0] p,
      input logic en, input logic [2:0] sel);
    logic [31:0] a;
    a = p;
    if (en) begin
      case (sel)
        `VSD_RING_64K: a[`VSD_RBIT_64K] = 1'b0;
        `VSD_RING_128K: a[`VSD_RBIT_128K] = 1'b0;
        `VSD_RING_256K: a[`VSD_RBIT_256K] = 1'b0;
        default: a = p;
      endcase
    end
    return a;
  endfunction : ring_map

  assign o_bit = cur_word[0];
  assign o_bit_valid = (cur_cnt != 6'h00);
  assign load = pre_valid && (cur_cnt == 6'h00 ||
    (i_take && cur_cnt == 6'h01));

  // Pointer: aligned on load, +2 per word, never decremented
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ptr <= 32'h0000_0000;
    end else if (i_plo_we) begin
      o_ptr[15:0] <= {i_wdata[15:2], 2'b00};
    end else if (i_phi_we) begin
      o_ptr[31:16] <= i_wdata;
    end else if (i_mem_ack && !drop) begin
      o_ptr <= o_ptr + `VSD_QW_STEP;
    end
  end

  // Request stays stable until acked; a stale answer is dropped
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_mem <= '0;
      drop <= 1'b0;
    end else begin
      if (i_plo_we && o_mem.req && !i_mem_ack) begin
        drop <= 1'b1;
      end else if (i_mem_ack) begin
        drop <= 1'b0;
      end
      if (i_mem_ack) begin
        o_mem.req <= 1'b0;
      end else if (!o_mem.req && !pre_valid && !i_plo_we) begin
        o_mem.req <= 1'b1;
        o_mem.addr <= ring_map(o_ptr, i_ring_en, i_ring_sel);
      end
    end
  end

  // One word of prefetch beside the word being decoded
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_plo_we) begin
      pre_valid <= 1'b0;
      pre_word <= 32'h0000_0000;
    end else if (i_mem_ack && !drop) begin
      pre_valid <= 1'b1;
      pre_word <= i_mem_data;
    end else if (load) begin
      pre_valid <= 1'b0;
    end
  end

  // Bits leave from the LSB upward, then the next word's LSB
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || i_plo_we) begin
      cur_cnt <= 6'h00;
      cur_word <= 32'h0000_0000;
    end else if (load) begin
      cur_word <= pre_word;
      cur_cnt <= `VSD_WORD_BITS;
    end else if (i_take && o_bit_valid) begin
      cur_word <= {1'b0, cur_word[31:1]};
      cur_cnt <= cur_cnt - 6'h01;
    end
  end
endmodule : vsd_fetch
`default_nettype wire

// File: vsd_map.svh
`ifndef VSD_MAP_SVH
`define VSD_MAP_SVH
// Register offsets on the plain port
`define VSD_A_CTRL 3'h0
`define VSD_A_TABLE 3'h1
`define VSD_A_DATA 3'h2
`define VSD_A_HOLD 3'h3
`define VSD_A_PLO 3'h4
`define VSD_A_PHI 3'h5
`define VSD_A_RING 3'h6
`define VSD_A_STAT 3'h7
// Reset values
`define VSD_CTRL_RST 16'h0000
`define VSD_RING_RST 3'h0
// Ring size codes and the word-address bit each one forces low
`define VSD_RING_64K 3'h0
`define VSD_RING_128K 3'h1
`define VSD_RING_256K 3'h2
`define VSD_RBIT_64K 15
`define VSD_RBIT_128K 16
`define VSD_RBIT_256K 17
// Fetch and decode counts
`define VSD_QW_STEP 32'h0000_0002
`define VSD_WORD_BITS 6'h20
`define VSD_RUN_MAX 3'h7
`endif

// File: vsd_mem_model.sv
`timescale 1ns/10ps
`default_nettype none
module vsd_mem_model import vsd_pkg::*; (
  input wire logic i_clk, // Clock
  input wire logic i_sys_rst, // Sync reset
  input wire vsd_mem_req_t i_mem, // Fetch request
  input wire logic i_slow, // Answer late
  output logic o_ack, // Fetch done
  output logic [31:0] o_data // Fetched word
);
  logic [31:0] words [4];
  int wait_n = 0;
  // Sample words; the upper pair is the lower pair inverted
  initial begin
    words[0] = 32'hAC98_E14D;
    words[1] = 32'h372E_74CB;
    words[2] = 32'h5367_1EB2;
    words[3] = 32'hC8D1_8B34;
    o_ack = 1'b0;
    o_data = 32'h0000_0000;
  end
  // One answer per request; idle data toggles so stale words never pass
  always @(posedge i_clk) begin
    if (i_sys_rst || !i_mem.req || o_ack) begin
      o_ack <= 1'b0;
      o_data <= ~o_data;
      wait_n <= 0;
    end else if (wait_n < (i_slow ? 5 : 0)) begin
      wait_n <= wait_n + 1;
    end else begin
      o_ack <= 1'b1;
      o_data <= words[i_mem.addr[2:1]] & {32{i_mem.addr[31:3] == '0}};
    end
  end
endmodule : vsd_mem_model
`default_nettype wire

// File: vsd_pkg.sv
package vsd_pkg;
  // Decoder states, Gray coded along idle-runin-xbits-done
  typedef enum logic [1:0] {
    vsd_st_idle = 2'b00,
    vsd_st_runin = 2'b01,
    vsd_st_xbits = 2'b11,
    vsd_st_done = 2'b10
  } vsd_state_t;
  // Control word layout
  typedef struct packed {
    logic runin_polarity;
    logic rsvd14;
    logic ring_buffer_enable;
    logic [4:0] uniform_xbit_value;
    logic short_mode;
    logic end_mode;
    logic test;
    logic write;
    logic rsvd3;
    logic [2:0] start_idx;
  } vsd_ctrl_t;
  // Code description table entry
  typedef struct packed {
    logic end_flag;
    logic [6:0] xval;
  } vsd_entry_t;
  // Memory fetch request
  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } vsd_mem_req_t;
endpackage : vsd_pkg

// File: vsd_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "vsd_map.svh"
module vsd_top import vsd_pkg::*; (
  input wire logic i_clk, // 125 MHz clock
  input wire logic i_sys_rst, // Sync reset, high
  input wire logic [2:0] i_addr, // Register address
  input wire logic [15:0] i_wdata, // Write data
  input wire logic i_wr, // Write strobe
  input wire logic i_rd, // Read strobe
  output logic [15:0] o_rdata, // Read data
  output logic o_rvalid, // Read data valid
  output logic o_stall, // Data read waiting
  output vsd_mem_req_t o_mem, // Memory request
  input wire logic i_mem_ack, // Memory done
  input wire logic [31:0] i_mem_data // Memory word
);
  vsd_ctrl_t ctrl;
  vsd_entry_t code_tab [8];
  logic [2:0] tab_idx;
  logic [2:0] ring_sel;
  vsd_state_t state;
  vsd_state_t next_state;
  logic [2:0] runs;
  logic [15:0] base;
  logic [15:0] xacc;
  logic [2:0] xleft;
  logic pend_hold;
  logic [31:0] ptr;
  logic sbit;
  logic sbit_ok;
  logic take;
  logic wr_ctrl;
  logic wr_tab;
  logic rd_sym;
  logic rd_tab;
  logic deliver;
  logic hold_kind;
  logic go;
  logic match;
  logic stop_end;
  vsd_ctrl_t wctrl;
  vsd_entry_t cur_e;
  logic [6:0] cur_v;
  logic [2:0] cur_n;

  // Number of x-bits from a one-hot 2^X value
  function automatic logic [2:0] xbits_of(input logic [6:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if (v[i]) begin
        n = 3'(i);
      end
    end
    return n;
  endfunction : xbits_of

  // Symbol value from base and assembled x-bits
  function automatic logic [15:0] sym_value(input logic [15:0] b,
      input logic [15:0] x);
    return 16'(b + x);
  endfunction : sym_value

  // Strobe decode
  assign wctrl = vsd_ctrl_t'(i_wdata);
  assign wr_ctrl = i_wr && (i_addr == `VSD_A_CTRL);
  assign wr_tab = i_wr && (i_addr == `VSD_A_TABLE);
  assign rd_tab = i_rd && ctrl.test &&
    (i_addr == `VSD_A_DATA || i_addr == `VSD_A_HOLD);
  assign rd_sym = i_rd && !ctrl.test &&
    (i_addr == `VSD_A_DATA || i_addr == `VSD_A_HOLD);

  // A plain control write restarts a stopped decoder
  assign go = wr_ctrl && !wctrl.test && !wctrl.write;

  // A read waits for the symbol rather than seeing half of it
  assign deliver = (state == vsd_st_done) && (rd_sym || o_stall);
  assign hold_kind = o_stall ? pend_hold : (i_addr == `VSD_A_HOLD);

  // Entry for this run length; seven and above share entry seven
  assign cur_e = code_tab[runs];
  assign cur_v = ctrl.short_mode ?
    {2'b00, ctrl.uniform_xbit_value} : cur_e.xval;
  assign cur_n = xbits_of(cur_v);

  // Run-in bit is the inverse of the polarity bit
  assign match = (sbit != ctrl.runin_polarity);
  assign stop_end = ctrl.end_mode && cur_e.end_flag;

  // One bit per cycle while a symbol is open
  assign take = sbit_ok &&
    (state == vsd_st_runin || state == vsd_st_xbits);

  vsd_fetch u_fetch (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_plo_we(i_wr && i_addr == `VSD_A_PLO),
    .i_phi_we(i_wr && i_addr == `VSD_A_PHI),
    .i_wdata(i_wdata),
    .i_ring_en(ctrl.ring_buffer_enable),
    .i_ring_sel(ring_sel),
    .i_take(take),
    .o_bit(sbit),
    .o_bit_valid(sbit_ok),
    .o_ptr(ptr),
    .o_mem(o_mem),
    .i_mem_ack(i_mem_ack),
    .i_mem_data(i_mem_data)
  );

  // Control word and ring size register
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      ctrl <= vsd_ctrl_t'(`VSD_CTRL_RST);
      ring_sel <= `VSD_RING_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wctrl;
      end
      if (i_wr && i_addr == `VSD_A_RING) begin
        ring_sel <= i_wdata[2:0];
      end
    end
  end

  // Table index: zeroed by write or test, one step per access
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tab_idx <= 3'h0;
    end else if (wr_ctrl && (wctrl.write || wctrl.test)) begin
      tab_idx <= 3'h0;
    end else if ((wr_tab && ctrl.write) || rd_tab) begin
      tab_idx <= tab_idx + 3'h1;
    end
  end

  // Table storage; writes only count while the write bit is set
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        code_tab[i] <= '0;
      end
    end else if (wr_tab && ctrl.write) begin
      code_tab[tab_idx] <= vsd_entry_t'(i_wdata[7:0]);
    end
  end

  // Decoder state machine
  always_comb begin
    next_state = state;
    case (state)
      vsd_st_idle: begin
        if (go) begin
          next_state = vsd_st_runin;
        end
      end
      vsd_st_runin: begin
        if (sbit_ok && (!match || stop_end)) begin
          if (cur_n == 3'h0) begin
            next_state = vsd_st_done;
          end else begin
            next_state = vsd_st_xbits;
          end
        end
      end
      vsd_st_xbits: begin
        if (sbit_ok && xleft == 3'h1) begin
          next_state = vsd_st_done;
        end
      end
      vsd_st_done: begin
        if (deliver) begin
          // Holding read parks the decoder until a plain write
          next_state = hold_kind ? vsd_st_idle : vsd_st_runin;
        end
      end
      default: begin
        next_state = vsd_st_idle;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state <= vsd_st_idle;
    end else begin
      state <= next_state;
    end
  end

  // Run length, base and x-bit accumulation
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      runs <= 3'h0;
      base <= 16'h0000;
      xacc <= 16'h0000;
      xleft <= 3'h0;
    end else if ((state == vsd_st_idle && go) ||
        (deliver && !hold_kind)) begin
      runs <= 3'h0;
      base <= 16'h0000;
      xacc <= 16'h0000;
      xleft <= 3'h0;
    end else if (state == vsd_st_runin && sbit_ok) begin
      if (match) begin
        // Each run-in bit adds the entry it passes, or in short mode the uniform value, to the base
        base <= 16'(base + {9'h000, cur_v});
        if (stop_end) begin
          xleft <= cur_n;
        end else if (runs != `VSD_RUN_MAX) begin
          runs <= runs + 3'h1;
        end
      end else begin
        xleft <= cur_n;
      end
    end else if (state == vsd_st_xbits && sbit_ok) begin
      xacc <= {xacc[14:0], sbit};
      xleft <= xleft - 3'h1;
    end
  end

  // Stall flag for a read that came before the symbol finished
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_stall <= 1'b0;
      pend_hold <= 1'b0;
    end else if (deliver) begin
      o_stall <= 1'b0;
    end else if (rd_sym) begin
      o_stall <= 1'b1;
      pend_hold <= (i_addr == `VSD_A_HOLD);
    end
  end

  // Read data, one cycle after the strobe or on a late delivery
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 16'h0000;
      o_rvalid <= 1'b0;
    end else begin
      o_rvalid <= 1'b0;
      if (deliver) begin
        o_rdata <= sym_value(base, xacc);
        o_rvalid <= 1'b1;
      end else if (rd_tab) begin
        o_rdata <= {8'h00, code_tab[tab_idx]};
        o_rvalid <= 1'b1;
      end else if (i_rd && !rd_sym) begin
        o_rvalid <= 1'b1;
        case (i_addr)
          `VSD_A_CTRL: o_rdata <= ctrl;
          `VSD_A_PLO: o_rdata <= ptr[15:0];
          `VSD_A_PHI: o_rdata <= ptr[31:16];
          `VSD_A_RING: o_rdata <= {13'h0000, ring_sel};
          `VSD_A_STAT: o_rdata <= {9'h000, o_stall, runs,
            1'b0, state};
          default: o_rdata <= 16'h0000;
        endcase
      end
    end
  end
endmodule : vsd_top
`default_nettype wire
